// *** inc/fpf_pkg.sv ***
// Constants, layouts and carriers for the dual fixed-point filter cores
package fpf_pkg;

   // Core count and storage sizes
   localparam int FPF_CORES = 2;
   localparam int FPF_MEM_WORDS = 48;
   localparam logic [5:0] FPF_PC_LAST = 6'h2f;
   localparam logic [1:0] FPF_TABLE_HI = 2'h2;
   localparam logic [3:0] FPF_DIV_LAST = 4'h7;

   // Byte offsets inside one core window; core select is address bit 10
   localparam int FPF_ADDR_W = 12;
   localparam int FPF_CORE_BIT = 10;
   localparam logic [9:0] FPF_OFF_CTRL = 10'h000;
   localparam logic [9:0] FPF_OFF_STAT = 10'h004;
   localparam logic [9:0] FPF_OFF_ACCL = 10'h008;
   localparam logic [9:0] FPF_OFF_ACCH = 10'h00c;
   localparam logic [9:0] FPF_OFF_CONST = 10'h020;
   localparam logic [9:0] FPF_OFF_SFB = 10'h040;
   localparam logic [9:0] FPF_OFF_EXT = 10'h060;
   localparam logic [9:0] FPF_OFF_MEM = 10'h100;
   localparam logic [9:0] FPF_OFF_MEM_END = 10'h1bc;

   // Control register field positions
   localparam int FPF_CTRL_EN = 0;
   localparam int FPF_CTRL_CONST = 1;
   localparam int FPF_CTRL_TABLE = 2;

   // Opcode field values
   localparam logic [2:0] FPF_OP_MISC = 3'h0;
   localparam logic [2:0] FPF_OP_JUMP = 3'h1;
   localparam logic [2:0] FPF_OP_MUL = 3'h2;
   localparam logic [2:0] FPF_OP_MAC = 3'h3;
   localparam logic [2:0] FPF_OP_DIV = 3'h4;
   localparam logic [2:0] FPF_OP_LSHIFT = 3'h5;
   localparam logic [2:0] FPF_OP_RSHIFT = 3'h6;
   localparam logic [2:0] FPF_OP_CHAIN = 3'h7;
   localparam logic [2:0] FPF_SEL_CLAMP = 3'h1;
   localparam logic [2:0] FPF_SEL_LIMLD = 3'h2;

   // Arithmetic limits and reciprocal seed
   localparam logic [35:0] FPF_ACC_MAX = 36'h7_ffff_ffff;
   localparam logic [35:0] FPF_ACC_MIN = 36'h8_0000_0000;
   localparam logic [16:0] FPF_NR_SEED = 17'h06000;
   localparam logic [16:0] FPF_NR_TWO = 17'h10000;
   localparam logic [15:0] FPF_RECIP_MAX = 16'h7fff;
   localparam logic [1:0] FPF_RESP_OK = 2'h0;
   localparam logic [1:0] FPF_RESP_ERR = 2'h2;

   // Data register write from the event unit or transfer controller
   typedef struct packed {
      logic valid;
      logic core;
      logic [2:0] idx;
      logic [15:0] data;
   } fpf_dwr_s;

   // One filter core
   typedef struct packed {
      logic [15:0][15:0] r;
      logic [7:0][15:0] c;
      logic [35:0] acc;
      logic [2:0][15:0] upper_limits;
      logic [2:0][15:0] lower_limits;
      logic [47:0][15:0] mem;
      logic [5:0] pc;
      logic en;
      logic const_en;
      logic table_en;
      logic [7:0] trig_pend;
      logic [3:0] div_cnt;
      logic [16:0] dn;
      logic [16:0] x;
      logic [4:0] lead;
      logic dneg;
      logic evt;
   } fpf_core_s;

   // Register slave state
   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_got;
      logic w_got;
      logic [FPF_ADDR_W-1:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } fpf_bus_s;

   typedef struct packed {
      fpf_core_s [FPF_CORES-1:0] core;
      fpf_bus_s bus;
   } fpf_state_s;

endpackage : fpf_pkg

// *** logic/fpf_dsp_top.sv ***
// Two fixed-point filter cores behind an AXI4-Lite register slave
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Two independent cores run concurrently
// - Sixteen data, eight constants, 36-bit accumulator
// - Data register writes trigger; core emits events
// - R0-R7 special bus; R8-R15 extended bus
// - Accumulator bus accessible; fed by mul/add/div
// - Accumulator overflow saturates to 36-bit limits
// - Multiplier: 16x16 to 32-bit product
// - Adder sums two 36-bit operands
// - Right shifter slices accumulator, saturates result
// - Right shift rounds to nearest
// - Divide: Newton-Raphson reciprocal times dividend
// - Clamp register between selected limits
// - Private 48-word 16-bit program memory
// - Constant registers usable as multiply operands
// - R15 reads table words 32 to 47
// - Clamp, limit load, shift-out lack flags
// - Trigger-wait flag holds instruction
// - Bits 14:12 pick triggering register R0-R7
// - Event bit emits event on execution
// - Operand fields pick registers or shift
// - Clamp limit selector above two means zero
// - Limit load bit3 picks lower/upper
// - Other opcode-zero words are no-ops
module fpf_dsp_top
   import fpf_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [FPF_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [FPF_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire fpf_dwr_s data_wr,
   output logic [FPF_CORES-1:0] core_event
);

   fpf_state_s st;
   fpf_state_s n;
   logic ev_fire0;
   logic hold0;

   // Saturate a wide signed result into the accumulator range
   function automatic logic [35:0] sat36(input logic signed [51:0] v);
      if (v > $signed({16'h0000, FPF_ACC_MAX}))
         sat36 = FPF_ACC_MAX;
      else if (v < $signed({16'hffff, FPF_ACC_MIN}))
         sat36 = FPF_ACC_MIN;
      else
         sat36 = v[35:0];
   endfunction : sat36

   // Round-to-nearest arithmetic right shift, saturated to 16 bits
   function automatic logic [15:0] shift_out(input logic [35:0] a,
                                             input logic [3:0] sh);
      logic signed [36:0] t;
      t = $signed({a[35], a});
      if (sh != 4'h0)
         t = t + (37'sd1 <<< (sh - 4'h1));
      t = t >>> sh;
      if (t > 37'sd32767)
         shift_out = 16'h7fff;
      else if (t < -37'sd32768)
         shift_out = 16'h8000;
      else
         shift_out = t[15:0];
   endfunction : shift_out

   // Merge byte lanes into a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] ws);
      merge16 = {ws[1] ? wd[15:8] : old[15:8], ws[0] ? wd[7:0] : old[7:0]};
   endfunction : merge16

   // Position of the leading one of a divisor magnitude
   function automatic logic [4:0] lead_one(input logic [16:0] m);
      lead_one = 5'h00;
      for (int i = 0; i < 16; i++)
         if (m[i])
            lead_one = 5'(i);
   endfunction : lead_one

   // Program counter step, wrapping at the memory end
   function automatic logic [5:0] pc_step(input logic [5:0] pc);
      pc_step = (pc >= FPF_PC_LAST) ? 6'h00 : pc + 6'h01;
   endfunction : pc_step

   // Next-state logic: core execution, then bus, then triggers
   always_comb begin
      fpf_core_s cs;
      fpf_core_s nc;
      logic [15:0] ins;
      logic [2:0] op;
      logic [2:0] tsel;
      logic [3:0] fa;
      logic [3:0] fb;
      logic flagged;
      logic go;
      logic signed [15:0] rn;
      logic signed [15:0] rm;
      logic signed [31:0] prod;
      logic [16:0] mag;
      logic [33:0] wide;
      logic [16:0] tq;
      logic [16:0] recip;
      logic signed [15:0] rs;
      logic [1:0] us;
      logic [1:0] ls;
      logic [9:0] off;
      logic hit;
      logic [31:0] rd;
      cs = '0;
      nc = '0;
      ins = '0;
      op = '0;
      tsel = '0;
      fa = '0;
      fb = '0;
      flagged = 1'b0;
      go = 1'b0;
      rn = '0;
      rm = '0;
      prod = '0;
      mag = '0;
      wide = '0;
      tq = '0;
      recip = '0;
      rs = '0;
      us = '0;
      ls = '0;
      off = '0;
      hit = 1'b0;
      rd = '0;
      n = st;
      ev_fire0 = 1'b0;
      hold0 = 1'b0;
      for (int c = 0; c < FPF_CORES; c++) begin
         cs = st.core[c];
         nc = cs;
         nc.evt = 1'b0;
         ins = cs.mem[cs.pc];
         tsel = ins[14:12];
         op = ins[10:8];
         fa = ins[7:4];
         fb = ins[3:0];
         rn = $signed(cs.r[fb]);
         // constant bank replaces upper register operands
         if (cs.const_en && fa[3] && op >= FPF_OP_MUL && op <= FPF_OP_DIV)
            rm = $signed(cs.c[fa[2:0]]);
         else
            rm = $signed(cs.r[fa]);
         prod = rn * rm;
         // clamp, limit load and shift-out carry no flags
         flagged = !(op == FPF_OP_RSHIFT) && !(op == FPF_OP_MISC &&
            !ins[15] && !ins[11] &&
            (tsel == FPF_SEL_CLAMP || tsel == FPF_SEL_LIMLD));
         // wait until the selected trigger is pending
         go = !flagged || !ins[15] || cs.trig_pend[tsel];
         if (cs.en && cs.div_cnt != 4'h0) begin
            // Newton-Raphson steps reuse multiplier and adder
            if (cs.div_cnt != FPF_DIV_LAST) begin
               wide = 34'(cs.dn) * 34'(cs.x);
               tq = FPF_NR_TWO - wide[31:15];
               wide = 34'(cs.x) * 34'(tq);
               nc.x = wide[31:15];
               nc.div_cnt = cs.div_cnt + 4'h1;
            end else begin
               recip = cs.x >> cs.lead;
               rs = (cs.dn == 17'h0 || recip > 17'(FPF_RECIP_MAX)) ?
                  $signed(FPF_RECIP_MAX) : $signed(recip[15:0]);
               if (cs.dneg)
                  rs = -rs;
               prod = rn * rs;
               nc.acc = sat36(52'(prod));
               nc.div_cnt = 4'h0;
               nc.pc = pc_step(cs.pc);
            end
         end else if (cs.en && go) begin
            nc.pc = pc_step(cs.pc);
            // consume the trigger that released the instruction
            if (flagged && ins[15])
               nc.trig_pend[tsel] = 1'b0;
            // event on execution when the event bit is set
            nc.evt = flagged && ins[11];
            case (op)
               FPF_OP_MISC: begin
                  // anything but clamp or limit load is a no-op
                  if (!flagged && tsel == FPF_SEL_CLAMP) begin
                     // selector three falls back to limit zero
                     us = (fb[3:2] > 2'h2) ? 2'h0 : fb[3:2];
                     ls = (fb[1:0] > 2'h2) ? 2'h0 : fb[1:0];
                     // clamp back into the same register
                     if (rm > $signed(cs.upper_limits[us]))
                        nc.r[fa] = cs.upper_limits[us];
                     else if (rm < $signed(cs.lower_limits[ls]))
                        nc.r[fa] = cs.lower_limits[ls];
                  end else if (!flagged && fb[2:0] <= 3'h2) begin
                     // bit 3 chooses lower or upper limit
                     if (fb[3])
                        nc.lower_limits[fb[1:0]] = cs.r[fa];
                     else
                        nc.upper_limits[fb[1:0]] = cs.r[fa];
                  end
               end
               FPF_OP_JUMP: begin
                  // table window copies words 32..47 to R15
                  if (ins[7] && cs.table_en)
                     nc.r[15] = cs.mem[{FPF_TABLE_HI, fb}];
                  else
                     nc.pc = (ins[5:0] > FPF_PC_LAST) ? 6'h00 : ins[5:0];
               end
               FPF_OP_MUL: nc.acc = sat36(52'(prod));
               FPF_OP_MAC: nc.acc = sat36(52'($signed(cs.acc)) + 52'(prod));
               FPF_OP_DIV: begin
                  // Normalise the divisor to [1,2) before iterating
                  mag = rm[15] ? 17'(-$signed({rm[15], rm})) : 17'(rm);
                  nc.dneg = rm[15];
                  nc.lead = lead_one(mag);
                  nc.dn = 17'(mag << (5'd15 - lead_one(mag)));
                  nc.x = FPF_NR_SEED;
                  nc.div_cnt = 4'h1;
                  nc.pc = cs.pc;
               end
               // second field is the left shift amount
               FPF_OP_LSHIFT: nc.acc = sat36(52'(rm) <<< fb);
               // rounded right shift into any register
               FPF_OP_RSHIFT: nc.r[fa] = shift_out(cs.acc, fb);
               default: begin
                  // Chain move for the delay line, first to last
                  for (int i = 1; i < 16; i++)
                     if (i > fb && i <= fa)
                        nc.r[i] = cs.r[i-1];
               end
            endcase
         end
         if (c == 0) begin
            ev_fire0 = nc.evt;
            hold0 = cs.en && cs.div_cnt == 4'h0 && !go;
         end
         n.core[c] = nc;
      end

      // Write channels: take address and data in either order
      if (s_axi_awvalid && st.bus.awready) begin
         n.bus.aw_got = 1'b1;
         n.bus.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st.bus.wready) begin
         n.bus.w_got = 1'b1;
         n.bus.wdata = s_axi_wdata;
         n.bus.wstrb = s_axi_wstrb;
      end
      if (st.bus.bvalid && s_axi_bready)
         n.bus.bvalid = 1'b0;
      if (st.bus.aw_got && st.bus.w_got && !st.bus.bvalid) begin
         off = {st.bus.awaddr[9:2], 2'b00};
         hit = 1'b1;
         for (int c = 0; c < FPF_CORES; c++) begin
            if (st.bus.awaddr[FPF_CORE_BIT] == c[0] &&
                st.bus.awaddr[FPF_ADDR_W-1] == 1'b0) begin
               if (off == FPF_OFF_CTRL) begin
                  n.core[c].en = st.bus.wdata[FPF_CTRL_EN];
                  n.core[c].const_en = st.bus.wdata[FPF_CTRL_CONST];
                  n.core[c].table_en = st.bus.wdata[FPF_CTRL_TABLE];
               end else if (off == FPF_OFF_STAT) begin
                  // Out-of-range start address restarts at word zero
                  n.core[c].pc = (st.bus.wdata[5:0] > FPF_PC_LAST) ?
                     6'h00 : st.bus.wdata[5:0];
               end else if (off == FPF_OFF_ACCL) begin
                  n.core[c].acc[31:0] = st.bus.wdata;
               end else if (off == FPF_OFF_ACCH) begin
                  n.core[c].acc[35:32] = st.bus.wdata[3:0];
               end else if (off >= FPF_OFF_CONST && off < FPF_OFF_SFB) begin
                  n.core[c].c[off[4:2]] = merge16(st.core[c].c[off[4:2]],
                     st.bus.wdata, st.bus.wstrb);
               end else if (off >= FPF_OFF_SFB && off < FPF_OFF_EXT) begin
                  // low registers on the special function window
                  n.core[c].r[{1'b0, off[4:2]}] = merge16(
                     st.core[c].r[{1'b0, off[4:2]}], st.bus.wdata,
                     st.bus.wstrb);
                  n.core[c].trig_pend[off[4:2]] = 1'b1;
               end else if (off >= FPF_OFF_EXT && off < 10'h080) begin
                  // upper registers on the extended window only
                  n.core[c].r[{1'b1, off[4:2]}] = merge16(
                     st.core[c].r[{1'b1, off[4:2]}], st.bus.wdata,
                     st.bus.wstrb);
               end else if (off >= FPF_OFF_MEM && off <= FPF_OFF_MEM_END) begin
                  n.core[c].mem[6'(off[9:2] - 8'h40)] = merge16(
                     st.core[c].mem[6'(off[9:2] - 8'h40)], st.bus.wdata,
                     st.bus.wstrb);
               end else begin
                  hit = 1'b0;
               end
            end
         end
         if (st.bus.awaddr[FPF_ADDR_W-1])
            hit = 1'b0;
         n.bus.aw_got = 1'b0;
         n.bus.w_got = 1'b0;
         n.bus.bvalid = 1'b1;
         n.bus.bresp = hit ? FPF_RESP_OK : FPF_RESP_ERR;
      end
      n.bus.awready = !n.bus.aw_got && !n.bus.bvalid;
      n.bus.wready = !n.bus.w_got && !n.bus.bvalid;

      // outside writers update R0-R7 and arm triggers; set wins
      if (data_wr.valid) begin
         n.core[data_wr.core].r[{1'b0, data_wr.idx}] = data_wr.data;
         n.core[data_wr.core].trig_pend[data_wr.idx] = 1'b1;
      end

      // Read channel: one-cycle answer from current state
      if (st.bus.rvalid && s_axi_rready) begin
         n.bus.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st.bus.arready) begin
         off = {s_axi_araddr[9:2], 2'b00};
         cs = st.core[s_axi_araddr[FPF_CORE_BIT]];
         hit = !s_axi_araddr[FPF_ADDR_W-1];
         if (off == FPF_OFF_CTRL)
            rd = {29'h0, cs.table_en, cs.const_en, cs.en};
         else if (off == FPF_OFF_STAT)
            rd = {14'h0, cs.trig_pend, cs.div_cnt, cs.pc};
         else if (off == FPF_OFF_ACCL)
            rd = cs.acc[31:0];
         else if (off == FPF_OFF_ACCH)
            rd = {28'h0, cs.acc[35:32]};
         else if (off >= FPF_OFF_CONST && off < FPF_OFF_SFB)
            rd = {16'h0, cs.c[off[4:2]]};
         else if (off >= FPF_OFF_SFB && off < 10'h080)
            rd = {16'h0, cs.r[off[5:2]]};
         else if (off >= FPF_OFF_MEM && off <= FPF_OFF_MEM_END)
            rd = {16'h0, cs.mem[6'(off[9:2] - 8'h40)]};
         else
            hit = 1'b0;
         n.bus.rdata = hit ? rd : 32'h0;
         n.bus.rresp = hit ? FPF_RESP_OK : FPF_RESP_ERR;
         n.bus.rvalid = 1'b1;
      end
      // Address channel open whenever no answer is pending
      n.bus.arready = !n.bus.rvalid;
   end

   // Single state register, synchronous reset
   always_ff @(posedge aclk) begin
      if (!aresetn)
         st <= '0;
      else
         st <= n;
   end

   // Outputs straight from the state register
   assign s_axi_awready = st.bus.awready;
   assign s_axi_wready = st.bus.wready;
   assign s_axi_bvalid = st.bus.bvalid;
   assign s_axi_bresp = st.bus.bresp;
   assign s_axi_arready = st.bus.arready;
   assign s_axi_rvalid = st.bus.rvalid;
   assign s_axi_rdata = st.bus.rdata;
   assign s_axi_rresp = st.bus.rresp;
   always_comb begin
      for (int c = 0; c < FPF_CORES; c++)
         core_event[c] = st.core[c].evt;
   end

   // Divide occupies exactly eight cycles
   AST_DIV_CYCLES: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(st.core[0].div_cnt != 4'h0) |->
      ##6 (st.core[0].div_cnt == 4'h7) ##1 (st.core[0].div_cnt == 4'h0))
      else $error("divide length wrong");

   // Waiting instruction keeps the program counter
   AST_WAIT_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      hold0 && !(data_wr.valid && !data_wr.core) && !st.bus.aw_got
      |=> $stable(st.core[0].pc))
      else $error("held instruction advanced");

   // Event output follows execution of an event-marked instruction
   AST_EVENT: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 core_event[0] == $past(ev_fire0))
      else $error("event output mismatch");

   // Program counter stays inside memory
   AST_PC_RANGE: assert property (@(posedge aclk) disable iff (!aresetn)
      st.core[0].pc <= FPF_PC_LAST)
      else $error("program counter out of range");

   // Outside register write arms the selected trigger
   AST_TRIG_SET: assert property (@(posedge aclk) disable iff (!aresetn)
      data_wr.valid && !data_wr.core |=> st.core[0].trig_pend[$past(data_wr.idx)])
      else $error("trigger not armed");

   // Stopped core does not move
   AST_STOPPED: assert property (@(posedge aclk) disable iff (!aresetn)
      !st.core[0].en && !st.bus.aw_got ##1 !st.bus.aw_got |-> $stable(st.core[0].pc))
      else $error("disabled core ran");

   // Write response holds until accepted
   AST_BRESP_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");

   // Read answer one cycle after address acceptance
   AST_READ_LAT: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");

endmodule : fpf_dsp_top
`default_nettype wire

// *** tb/fpf_dsp_top_tb_top.sv ***
// Self-checking bench for the dual filter cores
`timescale 1ns/10ps
`default_nettype none
module fpf_dsp_top_tb_top
   import fpf_pkg::*;
;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic [FPF_CORES-1:0] core_event;
   logic [1:0][7:0] evt_cnt;
   fpf_dwr_s data_wr;
   int failures, total_checks, i, n;
   logic [15:0] a, b;
   logic [35:0] acc;
   localparam logic [15:0] JMP1 = {5'h0, FPF_OP_JUMP, 8'h01};

   fpf_dsp_top u_fpf_dsp_top (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .data_wr(data_wr),
      .core_event(core_event));
   fpf_partner u_fpf_partner (.aclk(aclk), .core_event(core_event),
      .data_wr(data_wr), .evt_cnt(evt_cnt));

   // Free-running 200 MHz clock
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   task automatic complete_run();
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [11:0] ad(input logic c, input logic [9:0] o);
      return {1'b0, c, o};
   endfunction : ad

   // Write burst: both channels offered together, bounded wait on answer
   task automatic axw(input logic [11:0] ad_i, input logic [31:0] d,
                      input logic [1:0] er);
      int k;
      awaddr <= ad_i; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (k == 50) begin failures++; complete_run(); end
      chk(36'(bresp), 36'(er));
      @(posedge aclk);
   endtask : axw

   // Read and compare data and response
   task automatic axr(input logic [11:0] ad_i, input logic [31:0] ed,
                      input logic [1:0] er);
      int k;
      araddr <= ad_i; arvalid <= 1'b1; rready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      if (k == 50) begin failures++; complete_run(); end
      chk(36'(rdata), 36'(ed));
      chk(36'(rresp), 36'(er));
      @(posedge aclk);
   endtask : axr

   // Load two words, restart at pc 0; cyc 0 leaves the core running
   task automatic run(input logic c, input logic [15:0] w0,
                      input logic [15:0] w1, input int cyc);
      axw(ad(c, FPF_OFF_MEM), {16'h0, w0}, FPF_RESP_OK);
      axw(ad(c, FPF_OFF_MEM + 10'h004), {16'h0, w1}, FPF_RESP_OK);
      axw(ad(c, FPF_OFF_STAT), 32'h0, FPF_RESP_OK);
      axw(ad(c, FPF_OFF_CTRL), 32'h1, FPF_RESP_OK);
      if (cyc > 0) begin
         repeat (cyc) @(posedge aclk);
         axw(ad(c, FPF_OFF_CTRL), 32'h0, FPF_RESP_OK);
      end
   endtask : run

   function automatic logic [35:0] mulx(input logic [15:0] x,
                                        input logic [15:0] y);
      longint p;
      p = $signed(x) * $signed(y);
      return p[35:0];
   endfunction : mulx

   // Round half up, then clamp to 16 bits
   function automatic logic [15:0] accumulator_shift_out(input logic [35:0] v36, input int s);
      longint v;
      v = $signed(v36);
      if (s > 0) v = (v + (64'sd1 <<< (s - 1))) >>> s;
      if (v > 32767) return 16'h7fff;
      if (v < -32768) return 16'h8000;
      return v[15:0];
   endfunction : accumulator_shift_out

   initial begin
      aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
      arvalid = 1'b0; rready = 1'b0; awaddr = '0; araddr = '0; wdata = '0;
      failures = 0; total_checks = 0;
      void'($urandom(32'h37658a26));
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axr(ad(1'b0, FPF_OFF_ACCH), 32'h0, FPF_RESP_OK);
      axw(12'h800, 32'h1, FPF_RESP_ERR);
      axr(ad(1'b0, 10'h010), 32'h0, FPF_RESP_ERR);
      // Random products on alternating cores through both register banks
      for (i = 0; i < 6; i++) begin
         a = 16'($urandom);
         b = 16'($urandom);
         axw(ad(i[0], FPF_OFF_EXT + 10'h004), {16'h0, a}, FPF_RESP_OK);
         axw(ad(i[0], FPF_OFF_SFB + 10'h008), {16'h0, b}, FPF_RESP_OK);
         axr(ad(i[0], FPF_OFF_EXT + 10'h004), {16'h0, a}, FPF_RESP_OK);
         run(i[0], {5'h0, FPF_OP_MUL, 8'h92}, JMP1, 8);
         acc = mulx(a, b);
         axr(ad(i[0], FPF_OFF_ACCL), acc[31:0], FPF_RESP_OK);
         axr(ad(i[0], FPF_OFF_ACCH), {28'h0, acc[35:32]}, FPF_RESP_OK);
      end
      // Accumulate past both 36-bit limits
      for (i = 0; i < 2; i++) begin
         acc = i[0] ? FPF_ACC_MIN : FPF_ACC_MAX;
         axw(ad(1'b0, FPF_OFF_SFB), 32'h8000, FPF_RESP_OK);
         axw(ad(1'b0, FPF_OFF_SFB + 10'h004), i[0] ? 32'h7fff : 32'h8000,
             FPF_RESP_OK);
         axw(ad(1'b0, FPF_OFF_ACCL), 32'h0, FPF_RESP_OK);
         axw(ad(1'b0, FPF_OFF_ACCH), 32'h0, FPF_RESP_OK);
         run(1'b0, {5'h0, FPF_OP_MAC, 8'h10}, {5'h0, FPF_OP_JUMP, 8'h00},
             200);
         axr(ad(1'b0, FPF_OFF_ACCL), acc[31:0], FPF_RESP_OK);
         axr(ad(1'b0, FPF_OFF_ACCH), {28'h0, acc[35:32]}, FPF_RESP_OK);
      end
      // Shift-out with rounding and clamping, first case rounds up
      for (i = 0; i < 8; i++) begin
         n = (i == 0) ? 4 : $urandom % 16;
         acc = (i == 0) ? 36'h19 : {4'h0, 32'($urandom) >> ($urandom % 20)};
         axw(ad(1'b1, FPF_OFF_ACCL), acc[31:0], FPF_RESP_OK);
         axw(ad(1'b1, FPF_OFF_ACCH), 32'h0, FPF_RESP_OK);
         run(1'b1, {5'h0, FPF_OP_RSHIFT, 4'(i), 4'(n)}, JMP1, 8);
         axr(ad(1'b1, FPF_OFF_SFB + 10'(4 * i)), {16'h0, accumulator_shift_out(acc, n)},
             FPF_RESP_OK);
      end
      // Zero divisor takes the largest reciprocal; then limit and clamp
      axw(ad(1'b0, FPF_OFF_SFB + 10'h004), 32'h0, FPF_RESP_OK);
      axw(ad(1'b0, FPF_OFF_SFB + 10'h008), {16'h0, a}, FPF_RESP_OK);
      run(1'b0, {5'h0, FPF_OP_DIV, 8'h12}, JMP1, 20);
      acc = mulx(a, FPF_RECIP_MAX);
      axr(ad(1'b0, FPF_OFF_ACCL), acc[31:0], FPF_RESP_OK);
      axr(ad(1'b0, FPF_OFF_ACCH), {28'h0, acc[35:32]}, FPF_RESP_OK);
      axw(ad(1'b0, FPF_OFF_SFB + 10'h004), 32'h100, FPF_RESP_OK);
      axw(ad(1'b0, FPF_OFF_SFB + 10'h008), 32'h7000, FPF_RESP_OK);
      run(1'b0, {5'h04, FPF_OP_MISC, 8'h10}, {5'h02, FPF_OP_MISC, 8'h20},
          20);
      axr(ad(1'b0, FPF_OFF_SFB + 10'h008), 32'h100, FPF_RESP_OK);
      // Held no-op waiting on register 5, with event
      run(1'b0, {1'b1, 3'h5, 1'b1, FPF_OP_MISC, 8'h00},
          {5'h0, FPF_OP_JUMP, 8'h00}, 0);
      repeat (20) @(posedge aclk);
      chk(36'(evt_cnt[0]), 36'h0);
      u_fpf_partner.fire(1'b0, 3'h3, 16'h1234);
      repeat (10) @(posedge aclk);
      chk(36'(evt_cnt[0]), 36'h0);
      u_fpf_partner.fire(1'b0, 3'h5, 16'h00a5);
      repeat (10) @(posedge aclk);
      chk(36'(evt_cnt[0]), 36'h1);
      axw(ad(1'b0, FPF_OFF_SFB + 10'h014), 32'h5, FPF_RESP_OK);
      repeat (10) @(posedge aclk);
      chk(36'(evt_cnt[0]), 36'h2);
      chk(36'(evt_cnt[1]), 36'h0);
      axw(ad(1'b0, FPF_OFF_CTRL), 32'h0, FPF_RESP_OK);
      axr(ad(1'b0, FPF_OFF_SFB + 10'h00c), 32'h1234, FPF_RESP_OK);
      complete_run();
   end
endmodule : fpf_dsp_top_tb_top
`default_nettype wire

// *** tb/fpf_partner.sv ***
// Event unit and transfer controller stand-in facing the cores
`timescale 1ns/10ps
`default_nettype none
module fpf_partner
   import fpf_pkg::*;
(
   input wire logic aclk,
   input wire logic [FPF_CORES-1:0] core_event,
   output fpf_dwr_s data_wr,
   output logic [1:0][7:0] evt_cnt
);
   initial begin
      data_wr = '0;
      evt_cnt = '0;
   end
   always @(posedge aclk) begin
      for (int i = 0; i < FPF_CORES; i++) begin
         if (core_event[i]) evt_cnt[i] <= evt_cnt[i] + 8'h01;
      end
   end
   // one-cycle write; idle data inverted so stale data never matches
   task automatic fire(input logic c, input logic [2:0] i,
                       input logic [15:0] d);
      data_wr <= '{1'b1, c, i, d};
      @(posedge aclk);
      data_wr <= '{1'b0, c, i, ~d};
   endtask : fire
endmodule : fpf_partner
`default_nettype wire
